// [core/ofc_top.v]
/*
 Fuse array controller: AXI4-Lite register slave, manual programming
 sequencer with pulse timing, lockable read window, low-power handshake.
 Assumes aclk and the low-power request share one clock domain.
*/
`timescale 1ns/1ps
`include "ofc_consts.vh"

module ofc_top #(
  parameter PULSE_CYC = `OFC_PULSE_CYC,
  parameter CNT_W     = 16
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Write address channel
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // Write data channel
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // Write response channel
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // Read address channel
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // Read data channel
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Power, clock and reset unit
  input  wire        lowpower_req,
  output reg         lowpower_ack
);

  // Byte-enable to bit mask
  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // Merge write data into an old register value under byte enables
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  strb;
    begin
      merge = (old & ~strb_mask(strb)) | (wd & strb_mask(strb));
    end
  endfunction

  // Software-visible state
  reg               enable_r;
  reg               fuse_source_read_enable_r;
  reg               fuse_source_program_enable_r;
  reg               manual_override_enable_r;
  reg               array_select_r;
  reg               program_pulse_control_r;
  reg  [9:0]        bit_offset_field_r;
  reg  [1:0]        block_select_field_r;
  reg  [3:0]        lock_r;
  // Program timing
  reg  [CNT_W-1:0]  pulse_cnt_r;
  reg               blown_r;
  // Bus state
  reg               aw_have_r;
  reg               w_have_r;
  reg  [11:0]       aw_addr_r;
  reg  [31:0]       w_data_r;
  reg  [3:0]        w_strb_r;
  reg               rd_pend_r;
  reg  [11:0]       ar_addr_r;

  wire              aw_hs;
  wire              w_hs;
  wire              ar_hs;
  wire              wr_go;
  wire              prog_gate;
  wire              prog_stb;
  wire [11:0]       prog_addr;
  wire              rd_on;
  wire [15:0]       arr_data;
  wire [31:0]       wr_old;
  wire [31:0]       wr_new;
  reg  [31:0]       reg_rd;
  reg               reg_hit;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs  = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;

  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ~rd_pend_r & ~s_axi_rvalid;

  // Write performed once both halves are held
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

  // Blow gate: all three manual enables, program source enable and no low-power request
  assign prog_gate = manual_override_enable_r & fuse_source_program_enable_r &
                     array_select_r & program_pulse_control_r & ~lowpower_req;

  // Full program address: block then offset within block
  assign prog_addr = {block_select_field_r, bit_offset_field_r};

  // One strobe per pulse; locked block never blown
  assign prog_stb = prog_gate & ~blown_r & ~lock_r[block_select_field_r] &
                    (pulse_cnt_r == PULSE_CYC[CNT_W-1:0] - 1'b1);

  // Array powered for reads only when enabled and sourced for reading
  assign rd_on = enable_r & fuse_source_read_enable_r & ~lowpower_req;

  ofc_fuse_array #(
    .WORDS (`OFC_HW_WORDS)
  ) u_array (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .prog_stb  (prog_stb),
    .prog_addr (prog_addr),
    .rd_addr   (s_axi_araddr[8:1]),
    .rd_data   (arr_data)
  );

  // Register read view
  always @* begin
    reg_rd  = 32'h0000_0000;
    reg_hit = 1'b1;
    case (ar_addr_r)
      `OFC_CTRL_OFS: begin
        reg_rd[`OFC_CTRL_ENABLE]  = enable_r;
        reg_rd[`OFC_CTRL_SRC_RD]  = fuse_source_read_enable_r;
        reg_rd[`OFC_CTRL_SRC_PRG] = fuse_source_program_enable_r;
      end
      `OFC_MANCTL_OFS: begin
        reg_rd[`OFC_MAN_OVR]   = manual_override_enable_r;
        reg_rd[`OFC_MAN_SEL]   = array_select_r;
        reg_rd[`OFC_MAN_PULSE] = program_pulse_control_r;
      end
      `OFC_MANADDR_OFS: begin
        reg_rd[`OFC_ADDR_LO_MSB:`OFC_ADDR_LO_LSB] = bit_offset_field_r;
        reg_rd[`OFC_ADDR_HI_MSB:`OFC_ADDR_HI_LSB] = block_select_field_r;
      end
      `OFC_LOCK_OFS: begin
        reg_rd[3:0] = lock_r;
      end
      `OFC_STATUS_OFS: begin
        reg_rd[`OFC_STAT_ACTIVE] = prog_gate;
        reg_rd[`OFC_STAT_BLOWN]  = blown_r;
        reg_rd[`OFC_STAT_LOWPWR] = lowpower_ack;
      end
      default: begin
        reg_hit = 1'b0;
      end
    endcase
  end

  assign wr_old = (aw_addr_r == `OFC_CTRL_OFS) ?
                  {26'h0, fuse_source_program_enable_r, fuse_source_read_enable_r, 3'h0, enable_r} :
                  (aw_addr_r == `OFC_MANCTL_OFS) ?
                  {29'h0, program_pulse_control_r, array_select_r, manual_override_enable_r} :
                  (aw_addr_r == `OFC_MANADDR_OFS) ?
                  {20'h0, block_select_field_r, bit_offset_field_r} :
                  32'h0000_0000;
  assign wr_new = merge(wr_old, w_data_r, w_strb_r);

  // Write channels and register updates
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r                    <= 1'b0;
      w_have_r                     <= 1'b0;
      aw_addr_r                    <= 12'h000;
      w_data_r                     <= 32'h0000_0000;
      w_strb_r                     <= 4'h0;
      s_axi_bvalid                 <= 1'b0;
      s_axi_bresp                  <= `OFC_RESP_OKAY;
      enable_r                     <= |(`OFC_CTRL_RST & (6'h01 << `OFC_CTRL_ENABLE));
      fuse_source_read_enable_r    <= |(`OFC_CTRL_RST & (6'h01 << `OFC_CTRL_SRC_RD));
      fuse_source_program_enable_r <= |(`OFC_CTRL_RST & (6'h01 << `OFC_CTRL_SRC_PRG));
      manual_override_enable_r     <= 1'b0;
      array_select_r               <= 1'b0;
      program_pulse_control_r      <= 1'b0;
      bit_offset_field_r           <= 10'h000;
      block_select_field_r         <= 2'h0;
      lock_r                       <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (w_hs) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `OFC_RESP_OKAY;
        case (aw_addr_r)
          `OFC_CTRL_OFS: begin
            enable_r                     <= wr_new[`OFC_CTRL_ENABLE];
            fuse_source_read_enable_r    <= wr_new[`OFC_CTRL_SRC_RD];
            fuse_source_program_enable_r <= wr_new[`OFC_CTRL_SRC_PRG];
          end
          `OFC_MANCTL_OFS: begin
            manual_override_enable_r <= wr_new[`OFC_MAN_OVR];
            array_select_r           <= wr_new[`OFC_MAN_SEL];
            program_pulse_control_r  <= wr_new[`OFC_MAN_PULSE];
          end
          `OFC_MANADDR_OFS: begin
            bit_offset_field_r <= wr_new[`OFC_ADDR_LO_MSB:`OFC_ADDR_LO_LSB];
            // Block change while selected would glitch the array: held
            if (!array_select_r) begin
              block_select_field_r <= wr_new[`OFC_ADDR_HI_MSB:`OFC_ADDR_HI_LSB];
            end
          end
          `OFC_LOCK_OFS: begin
            // Locks only set; cleared by reset alone
            if (w_strb_r[0]) begin
              lock_r <= lock_r | w_data_r[3:0];
            end
          end
          `OFC_STATUS_OFS: begin
          end
          default: begin
            s_axi_bresp <= `OFC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Program pulse timing
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_r <= {CNT_W{1'b0}};
      blown_r     <= 1'b0;
    end else if (!prog_gate) begin
      // Pulse dropped: next high time starts a fresh operation
      pulse_cnt_r <= {CNT_W{1'b0}};
      blown_r     <= 1'b0;
    end else begin
      if (pulse_cnt_r != PULSE_CYC[CNT_W-1:0] - 1'b1) begin
        pulse_cnt_r <= pulse_cnt_r + 1'b1;
      end
      if (prog_stb) begin
        blown_r <= 1'b1;
      end
    end
  end

  // Read channel: address taken, array read, answer next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_r    <= 1'b0;
      ar_addr_r    <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OFC_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        rd_pend_r <= 1'b1;
        ar_addr_r <= s_axi_araddr;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_pend_r) begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `OFC_RESP_OKAY;
        if (ar_addr_r[`OFC_WIN_HI_MSB:`OFC_WIN_HI_LSB] == `OFC_WIN_HI) begin
          // Locked or unpowered blocks read as zero
          if (rd_on && !lock_r[ar_addr_r[8:7]]) begin
            s_axi_rdata <= {arr_data, arr_data};
          end else begin
            s_axi_rdata <= 32'h0000_0000;
          end
        end else if (reg_hit && ar_addr_r[1:0] == 2'h0) begin
          s_axi_rdata <= reg_rd;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `OFC_RESP_SLVERR;
        end
      end
    end
  end

  // Low-power acknowledge held off while pulse control is high and blown_r is set
  always @(posedge aclk) begin
    if (!aresetn) begin
      lowpower_ack <= 1'b0;
    end else begin
      lowpower_ack <= lowpower_req & ~(program_pulse_control_r & blown_r);
    end
  end

endmodule

// [inc/ofc_consts.vh]
/*
 Register map, field positions, reset values and timing counts of the
 one-time-programmable fuse array controller.
 Assumes inclusion by bare name from the design files.
*/
`ifndef OFC_CONSTS_VH
`define OFC_CONSTS_VH

// Byte offsets on the register bus
`define OFC_CTRL_OFS        12'h000
`define OFC_MANCTL_OFS      12'h004
`define OFC_MANADDR_OFS     12'h008
`define OFC_LOCK_OFS        12'h00c
`define OFC_STATUS_OFS      12'h010
// Fuse read window, 0x800..0x9ff
`define OFC_WIN_HI          3'h4
`define OFC_WIN_HI_MSB      11
`define OFC_WIN_HI_LSB      9

// Control register fields
`define OFC_CTRL_ENABLE     0
`define OFC_CTRL_SRC_RD     4
`define OFC_CTRL_SRC_PRG    5
`define OFC_CTRL_RST        6'h10
// Manual control register fields
`define OFC_MAN_OVR         0
`define OFC_MAN_SEL         1
`define OFC_MAN_PULSE       2
// Manual address register fields
`define OFC_ADDR_LO_MSB     9
`define OFC_ADDR_LO_LSB     0
`define OFC_ADDR_HI_MSB     11
`define OFC_ADDR_HI_LSB     10
// Status register fields
`define OFC_STAT_ACTIVE     0
`define OFC_STAT_BLOWN      1
`define OFC_STAT_LOWPWR     2

// Array geometry
`define OFC_BLOCKS          4
`define OFC_BLOCK_BITS      1024
`define OFC_HW_WORDS        256

// Timing
`define OFC_CLK_MHZ         100
`define OFC_PULSE_NS        10000
`define OFC_PULSE_CYC       ((`OFC_PULSE_NS * `OFC_CLK_MHZ) / 1000)

// AXI responses
`define OFC_RESP_OKAY       2'h0
`define OFC_RESP_SLVERR     2'h2

`endif

// [core/ofc_fuse_array.v]
/*
 Fuse storage: 4K bits held as 256 halfwords, one bit set per strobe,
 registered halfword read port.
 Assumes one clock; reset stands for the blank, unprogrammed array.
*/
`timescale 1ns/1ps
`include "ofc_consts.vh"

module ofc_fuse_array #(
  parameter WORDS = `OFC_HW_WORDS
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Program side
  input  wire        prog_stb,
  input  wire [11:0] prog_addr,
  // Read side
  input  wire [7:0]  rd_addr,
  output reg  [15:0] rd_data
);

  reg [15:0] mem [0:WORDS-1];
  integer    i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
      rd_data <= 16'h0000;
    end else begin
      // Only ever ORs a one in; a blown bit returns to zero only on reset
      if (prog_stb) begin
        mem[prog_addr[11:4]][prog_addr[3:0]] <= 1'b1;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// [testbench/ofc_checker.sv]
/* Bus and power handshake assertions on the fuse controller top.
   Assumes one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module ofc_checker (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Write side
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [11:0] s_axi_awaddr,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  // Read side
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Power unit
  input logic        lowpower_req,
  input logic        lowpower_ack
);
  logic aw_win_r;
  logic ar_win_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Remember whether the pending access targets the fuse window
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_win_r <= 1'b0;
      ar_win_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        aw_win_r <= (s_axi_awaddr[11:9] == 3'h4);
      if (s_axi_arvalid && s_axi_arready)
        ar_win_r <= (s_axi_araddr[11:9] == 3'h4);
    end
  end
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_ans; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans; s_rd_take |-> ##[1:3] s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid |=> s_axi_bvalid ? (!$past(s_axi_bready) && $stable(s_axi_bresp)) : $past(s_axi_bready);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid |=> s_axi_rvalid ? (!$past(s_axi_rready) && $stable(s_axi_rdata)) : $past(s_axi_rready);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_rep; s_axi_rvalid && ar_win_r |-> s_axi_rdata[31:16] == s_axi_rdata[15:0]; endproperty
  a_rep: assert property (p_rep) else $error("halfword not replicated");
  property p_win_wr; s_axi_bvalid && aw_win_r |-> s_axi_bresp == 2'h2; endproperty
  a_win_wr: assert property (p_win_wr) else $error("window write accepted");
  property p_lp_on; $rose(lowpower_req) |-> ##[1:3] lowpower_ack; endproperty
  a_lp_on: assert property (p_lp_on) else $error("low power not acknowledged");
  property p_lp_off; $fell(lowpower_req) |-> ##[1:3] !lowpower_ack; endproperty
  a_lp_off: assert property (p_lp_off) else $error("low power ack stuck");
  property p_lp_zero;
    s_axi_rvalid && ar_win_r && lowpower_req && $past(lowpower_req, 3) |-> s_axi_rdata == 32'h0;
  endproperty
  a_lp_zero: assert property (p_lp_zero) else $error("window read in low power");
  property p_rst;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !lowpower_ack;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left outputs set");
endmodule
bind ofc_top ofc_checker u_chk (.*);

// [testbench/tb_top.sv]
/* Self-checking bench for the fuse controller top.
   Assumes ofc_consts.vh on the include path. */
`timescale 1ns/1ps
`include "ofc_consts.vh"
module tb_top;
  localparam logic [11:0] a_ct = `OFC_CTRL_OFS, a_mc = `OFC_MANCTL_OFS, a_ma = `OFC_MANADDR_OFS;
  localparam logic [1:0]  ok = `OFC_RESP_OKAY, se = `OFC_RESP_SLVERR;
  logic        aclk, aresetn, lowpower_req;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, rd_v;
  logic [3:0]  s_axi_wstrb, lck;
  logic [15:0] mdl [256];
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lowpower_ack;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  integer      errors, total_checks, seed, i;
  ofc_top #(.PULSE_CYC(20)) DUT (.*);
  always #5 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Response ready goes up with the request and drops once the answer is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, da, dw;
    da = 0;
    dw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    do begin
      @(negedge aclk);
      ta = s_axi_bvalid && s_axi_bready;
      if (ta) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) s_axi_bready <= 1'b0;
    end while (!ta);
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arvalid && s_axi_arready;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'b0;
    end while (!t);
    do begin
      @(negedge aclk);
      t = s_axi_rvalid && s_axi_rready;
      rd_v = s_axi_rdata;
      if (t) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
      if (t) s_axi_rready <= 1'b0;
    end while (!t);
  endtask
  task automatic blow(input logic [1:0] b, input logic [9:0] o, input logic [31:0] ov);
    wr(a_mc, ov, ok);
    wr(a_ma, {20'h0, b, o}, ok);
    wr(a_mc, ov | 32'h2, ok);
    repeat (10) @(posedge aclk);
    wr(a_mc, ov | 32'h6, ok);
    repeat (30) @(posedge aclk);
    rd(`OFC_STATUS_OFS, ok);
    chk("status", rd_v, {30'h0, ov[0] && !lck[b], ov[0]});
    wr(a_mc, ov | 32'h2, ok);
    repeat (10) @(posedge aclk);
    if (ov[0] && !lck[b]) mdl[{b, o[9:4]}][o[3:0]] = 1'b1;
  endtask
  // Odd halfwords are read as the upper byte only
  task automatic scan(input logic on);
    logic [15:0] h;
    for (int k = 0; k < 256; k++) begin
      h = (on && !lck[k[7:6]]) ? mdl[k] : 16'h0;
      rd(12'h800 + 12'(2 * k + k % 2), ok);
      if (k % 2) chk("window byte", {24'h0, rd_v[15:8]}, {24'h0, h[15:8]});
      else chk("window", rd_v, {h, h});
    end
  endtask
  initial begin
    {aclk, aresetn, lowpower_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    lck = 4'h0;
    seed = 11264;
    errors = 0;
    total_checks = 0;
    for (i = 0; i < 256; i++) mdl[i] = 16'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(a_ct, ok);
    chk("ctrl", rd_v, 32'h10);
    rd(12'h100, se);
    wr(12'h800, 32'h1, se);
    scan(0);
    $display("test reset state done");
    wr(a_mc, 32'h1, ok);
    wr(a_ct, 32'h0, ok);
    wr(a_ct, 32'h20, ok);
    for (i = 0; i < 8; i++) blow(i[2:1], 10'($random(seed)), 32'h1);
    blow(2'h1, 10'($random(seed)), 32'h0);
    wr(a_ma, 32'h0000_0c00, ok);
    rd(a_ma, ok);
    chk("held block", rd_v, 32'h0000_0400);
    wr(a_mc, 32'h0, ok);
    wr(a_ct, 32'h0, ok);
    wr(a_ct, 32'h11, ok);
    scan(1);
    $display("test program and read done");
    wr(`OFC_LOCK_OFS, 32'h4, ok);
    wr(`OFC_LOCK_OFS, 32'h0, ok);
    rd(`OFC_LOCK_OFS, ok);
    chk("lock", rd_v, 32'h4);
    lck = 4'h4;
    wr(a_mc, 32'h1, ok);
    wr(a_ct, 32'h1, ok);
    wr(a_ct, 32'h21, ok);
    blow(2'h2, 10'($random(seed)), 32'h1);
    wr(a_mc, 32'h0, ok);
    wr(a_ct, 32'h1, ok);
    wr(a_ct, 32'h11, ok);
    scan(1);
    $display("test lock done");
    @(posedge aclk);
    lowpower_req <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`OFC_STATUS_OFS, ok);
    chk("status", rd_v & 32'h4, 32'h4);
    scan(0);
    @(posedge aclk);
    lowpower_req <= 1'b0;
    repeat (4) @(posedge aclk);
    $display("test low power done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    lck = 4'h0;
    for (i = 0; i < 256; i++) mdl[i] = 16'h0;
    rd(a_ct, ok);
    chk("ctrl", rd_v, 32'h10);
    rd(`OFC_LOCK_OFS, ok);
    chk("lock", rd_v, 32'h0);
    s_axi_wstrb <= 4'h2;
    wr(a_ma, 32'hffff_ffff, ok);
    s_axi_wstrb <= 4'hf;
    rd(a_ma, ok);
    chk("addr strobe", rd_v, 32'h0000_0f00);
    wr(a_ct, 32'h11, ok);
    scan(1);
    $display("test second reset done");
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge aclk);
    errors++;
    complete_run();
  end
endmodule
